// ==== include/pdcs_pkg.sv ====
// Overview of operation
// - bit 0: correctable reporting enable, reset 0
// - bit 1: non-fatal reporting enable, reset 0
// - bit 2: fatal reporting enable, reset 0
// - bit 3: unsupported request reporting enable, reset 0
// - bit 4 relaxed ordering reads zero
// - bits 7:5 payload size, clamped, reset 0
// - bits 8 and 9 always read zero
// - bit 10 sticky aux power enable, reset 0
// - bit 11 no-snoop reads zero
// - bits 14:12 read request size hardwired zero
// - bit 16 correctable detected, write-one clears
// - bit 17 non-fatal detected, write-one clears
// - bit 18 fatal detected, write-one clears
// - bit 19 unsupported request detected, write-one clears
// - detected flags ignore the reporting enables
// - bit 20 aux power detected, reset 1
// - bit 21 transactions pending hardwired zero
// - supported payload maximum is 256 bytes
package pdcs_pkg;
   localparam int          AXI_ADDR_W  = 12;
   localparam logic [11:0] DEVCTL_ADDR = 12'h0E8;
   localparam int          CTL_EN_LSB  = 0;
   localparam int          CTL_EN_MSB  = 3;
   localparam int          CTL_MPS_LSB = 5;
   localparam int          CTL_MPS_MSB = 7;
   localparam int          CTL_AUX_EN  = 10;
   localparam int          ST_ERR_LSB  = 16;
   localparam int          ST_ERR_MSB  = 19;
   localparam int          ST_AUX_DET  = 20;
   localparam int          LANE_CTL_LO = 0;
   localparam int          LANE_CTL_HI = 1;
   localparam int          LANE_STAT   = 2;
   localparam logic [2:0]  MPS_256B    = 3'h1;
   localparam logic [2:0]  MPS_RST     = 3'h0;
   localparam logic        AUX_DET_RST = 1'h1;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_DECERR = 2'h3;

   typedef struct packed {
      logic unsupReq;
      logic fatal;
      logic nonFatal;
      logic corr;
   } pdcs_err_t;

   typedef struct packed {
      logic                  awvalid;
      logic [AXI_ADDR_W-1:0] awaddr;
      logic                  wvalid;
      logic [31:0]           wdata;
      logic [3:0]            wstrb;
      logic                  bready;
      logic                  arvalid;
      logic [AXI_ADDR_W-1:0] araddr;
      logic                  rready;
   } pdcs_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pdcs_axi_rsp_t;

   typedef struct packed {
      pdcs_err_t  errEn;
      logic [2:0] maxPayload;
      logic       auxPowerEn;
   } pdcs_ctrl_t;

   typedef struct packed {
      pdcs_axi_rsp_t rsp;
      logic          awHit;
      logic          awGot;
      logic          wGot;
      logic [31:0]   wData;
      logic [3:0]    wStrb;
      pdcs_ctrl_t    ctrl;
      pdcs_err_t     detected;
      logic          auxDetected;
      pdcs_err_t     report;
   } pdcs_state_t;
endpackage

// ==== logic/pdcs_dev_ctl_stat.sv ====
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module pdcs_dev_ctl_stat #(
   parameter logic [2:0] MPS_SUPPORTED = pdcs_pkg::MPS_256B
) (
   // clock and resets
   input  wire logic                    mclk,
   input  wire logic                    rst,
   input  wire logic                    hotRst,
   // register bus
   input  wire pdcs_pkg::pdcs_axi_req_t axiReq,
   output      pdcs_pkg::pdcs_axi_rsp_t axiRsp,
   // detection events and power sense
   input  wire pdcs_pkg::pdcs_err_t     errDetect,
   input  wire logic                    auxPowerDet,
   // steering outputs
   output      pdcs_pkg::pdcs_ctrl_t    ctrlOut,
   output      pdcs_pkg::pdcs_err_t     errReport
);

   function automatic logic addrHit(input logic [pdcs_pkg::AXI_ADDR_W-1:0] a);
      addrHit = (a[pdcs_pkg::AXI_ADDR_W-1:2] == pdcs_pkg::DEVCTL_ADDR[pdcs_pkg::AXI_ADDR_W-1:2]);
   endfunction

   // every bit not built from a field reads as zero
   function automatic logic [31:0] regWord(input pdcs_pkg::pdcs_state_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[pdcs_pkg::CTL_EN_MSB:pdcs_pkg::CTL_EN_LSB]   = s.ctrl.errEn;
      w[pdcs_pkg::CTL_MPS_MSB:pdcs_pkg::CTL_MPS_LSB] = s.ctrl.maxPayload;
      w[pdcs_pkg::CTL_AUX_EN]                        = s.ctrl.auxPowerEn;
      w[pdcs_pkg::ST_ERR_MSB:pdcs_pkg::ST_ERR_LSB]   = s.detected;
      w[pdcs_pkg::ST_AUX_DET]                        = s.auxDetected;
      regWord = w;
   endfunction

   function automatic logic [2:0] clampPayload(input logic [2:0] v);
      clampPayload = (v > MPS_SUPPORTED) ? MPS_SUPPORTED : v;
   endfunction

   pdcs_pkg::pdcs_state_t q;
   pdcs_pkg::pdcs_state_t d;
   logic                  wrFire;
   logic                  wrHit;
   pdcs_pkg::pdcs_err_t   clrMask;

   assign wrFire  = q.awGot && q.wGot && !q.rsp.bvalid;
   assign wrHit   = wrFire && q.awHit;
   assign clrMask = (wrHit && q.wStrb[pdcs_pkg::LANE_STAT])
                    ? q.wData[pdcs_pkg::ST_ERR_MSB:pdcs_pkg::ST_ERR_LSB]
                    : 4'h0;

   always_comb begin
      d = q;
      // address and data are taken independently, in either order
      if (axiReq.awvalid && q.rsp.awready) begin
         d.awGot       = 1'b1;
         d.awHit       = addrHit(axiReq.awaddr);
         d.rsp.awready = 1'b0;
      end
      if (axiReq.wvalid && q.rsp.wready) begin
         d.wGot       = 1'b1;
         d.wData      = axiReq.wdata;
         d.wStrb      = axiReq.wstrb;
         d.rsp.wready = 1'b0;
      end
      // readys reopen only after the response is taken
      if (q.rsp.bvalid && axiReq.bready) begin
         d.rsp.bvalid  = 1'b0;
         d.rsp.awready = 1'b1;
         d.rsp.wready  = 1'b1;
      end
      if (wrFire) begin
         d.awGot      = 1'b0;
         d.wGot       = 1'b0;
         d.rsp.bvalid = 1'b1;
         d.rsp.bresp  = q.awHit ? pdcs_pkg::RESP_OKAY : pdcs_pkg::RESP_DECERR;
      end
      // bits 4, 8, 9, 11, 14:12, 15 and 31:21 have no storage at all
      if (wrHit && q.wStrb[pdcs_pkg::LANE_CTL_LO]) begin
         d.ctrl.errEn      = q.wData[pdcs_pkg::CTL_EN_MSB:pdcs_pkg::CTL_EN_LSB];
         d.ctrl.maxPayload = clampPayload(
            q.wData[pdcs_pkg::CTL_MPS_MSB:pdcs_pkg::CTL_MPS_LSB]);
      end
      if (wrHit && q.wStrb[pdcs_pkg::LANE_CTL_HI]) begin
         d.ctrl.auxPowerEn = q.wData[pdcs_pkg::CTL_AUX_EN];
      end
      // a detection in the clearing cycle wins over the clear
      d.detected = (q.detected & ~clrMask) | errDetect;
      // enables gate only the report, never the logging
      d.report      = errDetect & q.ctrl.errEn;
      d.auxDetected = auxPowerDet;
      // one read at a time; data is the word as it stands when taken
      if (q.rsp.rvalid && axiReq.rready) begin
         d.rsp.rvalid  = 1'b0;
         d.rsp.arready = 1'b1;
      end
      if (axiReq.arvalid && q.rsp.arready) begin
         d.rsp.arready = 1'b0;
         d.rsp.rvalid  = 1'b1;
         d.rsp.rdata   = addrHit(axiReq.araddr) ? regWord(q) : 32'h0000_0000;
         d.rsp.rresp   = addrHit(axiReq.araddr) ? pdcs_pkg::RESP_OKAY
                                                 : pdcs_pkg::RESP_DECERR;
      end
      // conventional reset spares the sticky aux enable and the bus
      if (hotRst) begin
         d.ctrl.errEn      = 4'h0;
         d.ctrl.maxPayload = pdcs_pkg::MPS_RST;
         d.detected        = errDetect;
         d.report          = 4'h0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q                 <= '0;
         q.rsp.awready     <= 1'b1;
         q.rsp.wready      <= 1'b1;
         q.rsp.arready     <= 1'b1;
         q.ctrl.maxPayload <= pdcs_pkg::MPS_RST;
         q.auxDetected     <= pdcs_pkg::AUX_DET_RST;
      end else begin
         q <= d;
      end
   end

   assign axiRsp    = q.rsp;
   assign ctrlOut   = q.ctrl;
   assign errReport = q.report;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence sWriteTaken;
      wrFire;
   endsequence

   sequence sRespDone;
      axiRsp.bvalid ##0 axiReq.bready;
   endsequence

   sequence sHitClear;
      wrHit && q.wStrb[pdcs_pkg::LANE_STAT] && !hotRst;
   endsequence

   property pRespFollows;
      sWriteTaken |=> axiRsp.bvalid && !axiRsp.awready && !axiRsp.wready;
   endproperty

   property pReadyReturn;
      sRespDone |=> !axiRsp.bvalid && axiRsp.awready && axiRsp.wready;
   endproperty

   a_write_resp_order: assert property (pRespFollows)
      else $error("write response did not follow the taken write");

   a_ready_reopen: assert property (pReadyReturn)
      else $error("write channels did not reopen after response");

   a_ctrl_enables_wr: assert property (
      wrHit && q.wStrb[pdcs_pkg::LANE_CTL_LO] && !hotRst
      |=> ctrlOut.errEn == $past(q.wData[3:0]))
      else $error("reporting enables not written as given");

   a_payload_clamped: assert property (
      wrHit && q.wStrb[pdcs_pkg::LANE_CTL_LO] && !hotRst
      |=> ctrlOut.maxPayload == clampPayload($past(q.wData[7:5])))
      else $error("payload size not clamped correctly");

   a_payload_bound: assert property (ctrlOut.maxPayload <= MPS_SUPPORTED)
      else $error("payload size above supported maximum");

   a_aux_en_sticky: assert property (
      hotRst && !(wrHit && q.wStrb[pdcs_pkg::LANE_CTL_HI])
      |=> $stable(ctrlOut.auxPowerEn))
      else $error("aux enable lost on conventional reset");

   a_detect_wins_clear: assert property (
      sHitClear ##0 (errDetect != 4'h0)
      |=> (q.detected & $past(errDetect)) == $past(errDetect))
      else $error("detection lost to a clearing write");

   a_flag_cleared: assert property (
      sHitClear ##0 (errDetect == 4'h0)
      |=> q.detected == ($past(q.detected) & ~$past(clrMask)))
      else $error("write-one did not clear or write-zero altered a flag");

   a_log_without_en: assert property (
      (errDetect != 4'h0) && (q.ctrl.errEn == 4'h0)
      |=> ((q.detected & $past(errDetect)) == $past(errDetect)) && errReport == 4'h0)
      else $error("detection not logged while reporting disabled");

   a_report_gated: assert property (
      !hotRst |=> errReport == ($past(errDetect) & $past(q.ctrl.errEn)))
      else $error("report does not match event and enable");

   a_aux_det_track: assert property (
      auxPowerDet ##1 !auxPowerDet |=> !q.auxDetected ##1 $past(q.auxDetected, 2))
      else $error("aux detected bit does not follow the sense input");

   a_rsvd_read_zero: assert property (
      axiReq.arvalid && axiRsp.arready
      |=> (axiRsp.rdata & 32'hFFE0_FB10) == 32'h0000_0000)
      else $error("hardwired or reserved bits read non-zero");

   a_tp_bit_zero: assert property (
      axiRsp.rvalid |-> !axiRsp.rdata[21] && axiRsp.rdata[14:12] == 3'h0)
      else $error("pending or read size bits read non-zero");

   a_read_hold: assert property (
      axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
      else $error("read data changed before it was taken");

   // read channel steps
   sequence sReadTaken;
      axiReq.arvalid && axiRsp.arready;
   endsequence

   sequence sReadDone;
      axiRsp.rvalid ##0 axiReq.rready;
   endsequence

   a_en_corr_wr: assert property (
      wrHit && q.wStrb[pdcs_pkg::LANE_CTL_LO] && !hotRst
      |=> ctrlOut.errEn.corr == $past(q.wData[0]))
      else $error("correctable enable not written as given");

   a_en_nonfatal_wr: assert property (
      wrHit && q.wStrb[pdcs_pkg::LANE_CTL_LO] && !hotRst
      |=> ctrlOut.errEn.nonFatal == $past(q.wData[1]))
      else $error("non-fatal enable not written as given");

   a_en_fatal_wr: assert property (
      wrHit && q.wStrb[pdcs_pkg::LANE_CTL_LO] && !hotRst
      |=> ctrlOut.errEn.fatal == $past(q.wData[2]))
      else $error("fatal enable not written as given");

   a_en_unsup_wr: assert property (
      wrHit && q.wStrb[pdcs_pkg::LANE_CTL_LO] && !hotRst
      |=> ctrlOut.errEn.unsupReq == $past(q.wData[3]))
      else $error("unsupported request enable not written as given");

   a_relaxed_zero: assert property (
      axiRsp.rvalid
      |-> !axiRsp.rdata[4])
      else $error("relaxed ordering bit read non-zero");

   a_tag_phantom_zero: assert property (
      axiRsp.rvalid
      |-> axiRsp.rdata[9:8] == 2'h0)
      else $error("tag or phantom enable read non-zero");

   a_aux_en_wr: assert property (
      wrHit && q.wStrb[pdcs_pkg::LANE_CTL_HI]
      |=> ctrlOut.auxPowerEn == $past(q.wData[pdcs_pkg::CTL_AUX_EN]))
      else $error("aux power enable not written as given");

   a_no_snoop_zero: assert property (
      axiRsp.rvalid
      |-> !axiRsp.rdata[11])
      else $error("no-snoop bit read non-zero");

   a_rd_size_zero: assert property (
      axiRsp.rvalid
      |-> axiRsp.rdata[14:12] == 3'h0)
      else $error("read request size read non-zero");

   a_corr_set: assert property (
      errDetect.corr
      |=> q.detected.corr)
      else $error("correctable detection not logged");

   a_nonfatal_set: assert property (
      errDetect.nonFatal
      |=> q.detected.nonFatal)
      else $error("non-fatal detection not logged");

   a_fatal_set: assert property (
      errDetect.fatal
      |=> q.detected.fatal)
      else $error("fatal detection not logged");

   a_unsup_set: assert property (
      errDetect.unsupReq
      |=> q.detected.unsupReq)
      else $error("unsupported request detection not logged");

   a_report_only_en: assert property (
      !hotRst
      |=> (errReport & ~$past(q.ctrl.errEn)) == 4'h0)
      else $error("report raised for a disabled class");

   a_rsvd_high_zero: assert property (
      axiRsp.rvalid
      |-> !axiRsp.rdata[15] && axiRsp.rdata[31:22] == 10'h000)
      else $error("reserved bits read non-zero");

   a_zero_keeps_flag: assert property (
      sHitClear
      |=> (q.detected & $past(q.detected & ~clrMask)) == $past(q.detected & ~clrMask))
      else $error("write of zero altered a detected flag");

   a_detect_sticky: assert property (
      !hotRst && !(wrHit && q.wStrb[pdcs_pkg::LANE_STAT])
      |=> (q.detected & $past(q.detected)) == $past(q.detected))
      else $error("detected flag dropped without a clear");

   a_hot_clears_ctrl: assert property (
      hotRst
      |=> ctrlOut.errEn == 4'h0 && ctrlOut.maxPayload == pdcs_pkg::MPS_RST && errReport == 4'h0)
      else $error("conventional reset left control or report set");

   a_ctrl_hold: assert property (
      !wrHit && !hotRst
      |=> $stable(ctrlOut))
      else $error("control half changed without a write");

   a_bresp_code: assert property (
      sWriteTaken
      |=> axiRsp.bresp == ($past(q.awHit) ? pdcs_pkg::RESP_OKAY : pdcs_pkg::RESP_DECERR))
      else $error("write response code wrong for address");

   a_read_resp_next: assert property (
      sReadTaken
      |=> axiRsp.rvalid && !axiRsp.arready)
      else $error("read data did not follow the taken address");

   a_read_ready_back: assert property (
      sReadDone
      |=> !axiRsp.rvalid && axiRsp.arready)
      else $error("read channel did not reopen after data");

   a_read_decerr: assert property (
      sReadTaken ##0 !addrHit(axiReq.araddr)
      |=> axiRsp.rresp == pdcs_pkg::RESP_DECERR && axiRsp.rdata == 32'h0000_0000)
      else $error("unmapped read not refused");

   a_read_okay: assert property (
      sReadTaken ##0 addrHit(axiReq.araddr)
      |=> axiRsp.rresp == pdcs_pkg::RESP_OKAY)
      else $error("mapped read not answered okay");

endmodule

// ==== verification/tb_pdcs_dev_ctl_stat.sv ====
`timescale 1ns/1ps
module tb_pdcs_dev_ctl_stat;
   logic                    mclk        = 1'b0;
   logic                    rst         = 1'b1;
   logic                    hotRst      = 1'b0;
   pdcs_pkg::pdcs_axi_req_t axiReq      = '0;
   pdcs_pkg::pdcs_axi_rsp_t axiRsp;
   pdcs_pkg::pdcs_err_t     errDetect   = '0;
   logic                    auxPowerDet = 1'b1;
   pdcs_pkg::pdcs_ctrl_t    ctrlOut;
   pdcs_pkg::pdcs_err_t     errReport;
   int                      error_cnt   = 0;
   int                      compares    = 0;
   int                      seed        = 61475;
   int                      n;
   logic [3:0]              en, det;
   logic [2:0]              mps;
   logic                    aux, auxD;
   logic [31:0]             rd, d, r2;
   logic [1:0]              rsp;
   localparam logic [11:0]  REG = pdcs_pkg::DEVCTL_ADDR;

   pdcs_dev_ctl_stat pdcs_dev_ctl_stat_inst (.mclk(mclk), .rst(rst), .hotRst(hotRst),
      .axiReq(axiReq), .axiRsp(axiRsp), .errDetect(errDetect), .auxPowerDet(auxPowerDet),
      .ctrlOut(ctrlOut), .errReport(errReport));

   always #25 mclk = ~mclk;

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   function logic [31:0] expWord();
      return {11'h000, auxD, det, 5'h00, aux, 2'h0, mps, 1'h0, en};
   endfunction

   task summarize();
      if (error_cnt == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // e is raised so that it lands on the edge where the write acts
   task wr(input logic [11:0] a, input logic [31:0] dt, input logic [3:0] s, input logic [3:0] e);
      @(posedge mclk);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr  <= a;
      axiReq.wvalid  <= 1'b1;
      axiReq.wdata   <= dt;
      axiReq.wstrb   <= s;
      axiReq.bready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge mclk);
         if (axiReq.awvalid && axiRsp.awready) begin
            axiReq.awvalid <= 1'b0;
            errDetect      <= e;
         end else errDetect <= '0;
         if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
         if (axiRsp.bvalid) begin
            rsp = axiRsp.bresp;
            axiReq.bready <= 1'b0;
            break;
         end
      end
      if (n == 40) begin
         error_cnt++;
         summarize();
      end
      chk("bresp", (a == REG) ? 32'h0 : 32'h3, {30'h0, rsp});
      if (a == REG) begin
         if (s[0]) en = dt[3:0];
         if (s[0]) mps = (dt[7:5] > pdcs_pkg::MPS_256B) ? pdcs_pkg::MPS_256B : dt[7:5];
         if (s[1]) aux = dt[10];
         if (s[2]) det = det & ~dt[19:16];
      end
      det = det | e;
   endtask

   task rd32(input logic [11:0] a);
      @(posedge mclk);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr  <= a;
      axiReq.rready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge mclk);
         if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
         if (axiRsp.rvalid) begin
            rd  = axiRsp.rdata;
            rsp = axiRsp.rresp;
            axiReq.rready <= 1'b0;
            break;
         end
      end
      if (n == 40) begin
         error_cnt++;
         summarize();
      end
   endtask

   task checkAll();
      rd32(REG);
      chk("rresp", 32'h0, {30'h0, rsp});
      chk("word", expWord(), rd);
      chk("ctrlOut", {en, mps, aux}, {24'h0, ctrlOut});
   endtask

   task pulse(input logic [3:0] e);
      @(posedge mclk);
      errDetect <= e;
      @(posedge mclk);
      errDetect <= '0;
      #1;
      chk("errReport", {28'h0, e & en}, {28'h0, errReport});
      det = det | e;
   endtask

   initial begin
      #1_000_000;
      error_cnt++;
      summarize();
   end

   initial begin
      {aux, en, mps, det} = '0;
      auxD = 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      checkAll();
      pulse(4'hF);
      checkAll();
      wr(REG, 32'hFFFF_FFFF, 4'hF, 4'h5);
      checkAll();
      wr(REG, 32'h0000_04E0, 4'h7, 4'h0);
      checkAll();
      wr(12'h0EC, 32'hFFFF_FFFF, 4'hF, 4'h0);
      rd32(12'h0EC);
      chk("rresp", 32'h3, {30'h0, rsp});
      chk("rdata", 32'h0, rd);
      checkAll();
      repeat (40) begin
         d  = $random(seed);
         r2 = $random(seed);
         wr(REG, d, r2[3:0], r2[7:4]);
         auxPowerDet <= r2[12];
         auxD = r2[12];
         pulse(r2[11:8]);
         if (r2[15:13] == 3'h0) begin
            // conventional reset spares the sticky power enable
            @(posedge mclk);
            hotRst <= 1'b1;
            @(posedge mclk);
            hotRst <= 1'b0;
            {en, mps, det} = '0;
         end
         checkAll();
      end
      @(posedge mclk);
      auxPowerDet <= 1'b1;
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      {aux, en, mps, det} = '0;
      auxD = 1'b1;
      checkAll();
      summarize();
   end
endmodule
